// [hw/tmts_cfg.svh]
// Constants shared by both ends of the scan link: command fields, status bits, timing.
// Assumes it is included by bare name from files that also import tmts_pkg.
`ifndef TMTS_CFG_SVH
`define TMTS_CFG_SVH

// Command byte layout
`define TMTS_CMD_SOFTWARE_RESET_BIT    7
`define TMTS_CMD_OP_HI    6
`define TMTS_CMD_OP_LO    4
`define TMTS_CMD_END_HI   1
`define TMTS_CMD_END_LO   0

// Status byte layout and reset value
`define TMTS_STAT_FULL    6
`define TMTS_STAT_BUSY    0
`define TMTS_STAT_RST     8'h00

// Clock rate and TCK divider (reset rate is master clock / 16)
`define TMTS_CLK_NS       40
`define TMTS_TCK_DIV      16
// Worst-case master clocks until targets sit in Test-Logic-Reset after reset
`define TMTS_TLR_CLKS     72

// Outgoing buffer shape
`define TMTS_FIFO_W       8
`define TMTS_FIFO_DEPTH   4
`define TMTS_LEN_W        16

// Target end: register widths and the value captured into the instruction register
`define TMTS_IR_W         4
`define TMTS_DR_W         8
`define TMTS_IR_CAP       4'h1

`endif

// [hw/tmts_pkg.sv]
// Types shared by the scan master and the scan target: TAP states and commands.
// Assumes nothing beyond a SystemVerilog compiler.
package tmts_pkg;

   // TAP controller states, standard four-bit codes
   typedef enum logic [3:0] {
      ts_tlr   = 4'hf, ts_rti   = 4'hc, ts_seldr = 4'h7, ts_capdr = 4'h6,
      ts_shdr  = 4'h2, ts_ex1dr = 4'h1, ts_pdr   = 4'h3, ts_ex2dr = 4'h0,
      ts_updr  = 4'h5, ts_selir = 4'h4, ts_capir = 4'he, ts_shir  = 4'ha,
      ts_ex1ir = 4'h9, ts_pir   = 4'hb, ts_ex2ir = 4'h8, ts_upir  = 4'hd
   } tmts_state_type;

   // Scan command opcodes
   typedef enum logic [2:0] {
      op_move  = 3'h0, op_scan_dr = 3'h1, op_scan_ir = 3'h2,
      op_in_dr = 3'h3, op_recirc  = 3'h4
   } tmts_op_type;

   // Master sequencing phases
   typedef enum logic [1:0] {
      ph_idle = 2'h0, ph_go_shift = 2'h1, ph_shift = 2'h2, ph_go_end = 2'h3
   } tmts_phase_type;

   // One TCK rising edge of the 16-state diagram
   function automatic tmts_state_type tmts_next(input tmts_state_type s, input logic t);
      case (s)
         ts_tlr:   tmts_next = t ? ts_tlr   : ts_rti;
         ts_rti:   tmts_next = t ? ts_seldr : ts_rti;
         ts_seldr: tmts_next = t ? ts_selir : ts_capdr;
         ts_capdr: tmts_next = t ? ts_ex1dr : ts_shdr;
         ts_shdr:  tmts_next = t ? ts_ex1dr : ts_shdr;
         ts_ex1dr: tmts_next = t ? ts_updr  : ts_pdr;
         ts_pdr:   tmts_next = t ? ts_ex2dr : ts_pdr;
         ts_ex2dr: tmts_next = t ? ts_updr  : ts_shdr;
         ts_updr:  tmts_next = t ? ts_seldr : ts_rti;
         ts_selir: tmts_next = t ? ts_tlr   : ts_capir;
         ts_capir: tmts_next = t ? ts_ex1ir : ts_shir;
         ts_shir:  tmts_next = t ? ts_ex1ir : ts_shir;
         ts_ex1ir: tmts_next = t ? ts_upir  : ts_pir;
         ts_pir:   tmts_next = t ? ts_ex2ir : ts_pir;
         ts_ex2ir: tmts_next = t ? ts_upir  : ts_shir;
         ts_upir:  tmts_next = t ? ts_seldr : ts_rti;
         default:  tmts_next = ts_tlr;
      endcase
   endfunction

endpackage

// [hw/tmts_link_if.sv]
// Scan link between the master and a target: TCK, TMS, data both ways, test reset.
// Assumes both ends share clk_sys; the target's data line is pulled high when released.
`timescale 1ns/1ps
`default_nettype none
interface tmts_link_if;
   logic tck;       // Test clock from master
   logic tms;       // Mode select from master
   logic m2t_data;  // Master data out, target data in
   logic trst_n;    // Test reset, active low
   logic t2m_out;   // Target data out value
   logic t2m_oe;    // Target drives its data out
   logic t2m_data;  // Resolved line seen by the master

   // Pull-up stands in for the released line
   assign t2m_data = t2m_oe ? t2m_out : 1'b1;

   modport master (output tck, output tms, output m2t_data, output trst_n, input t2m_data);
   modport target (input tck, input tms, input m2t_data, input trst_n,
                   output t2m_out, output t2m_oe);
endinterface
`default_nettype wire

// [hw/tmts_master.sv]
// Scan master: TAP-state generator, TCK divider and outgoing byte FIFO serializer.
// Assumes host strobes are synchronous to clk_sys and the link joins it to a target.
`timescale 1ns/1ps
`default_nettype none
`include "tmts_cfg.svh"

module tmts_fifo
   import tmts_pkg::*;
#(
   parameter int W = `TMTS_FIFO_W,
   parameter int D = `TMTS_FIFO_DEPTH
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         flush,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;

   initial begin
      if (D < 2 || (D & (D - 1)) != 0) $error("tmts_fifo depth must be a power of two >= 2");
   end

   logic [W-1:0]  mem_q [D];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0]   cnt_q, cnt_d;
   logic          rdy_q, rdy_d, vld_q, vld_d, push, pop;

   // Pointer and occupancy update; flush wins over traffic in the same cycle
   always_comb begin
      push  = in_valid & rdy_q;
      pop   = out_ready & vld_q;
      wp_d  = wp_q + AW'(push);
      rp_d  = rp_q + AW'(pop);
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      if (flush) begin
         wp_d  = '0;
         rp_d  = '0;
         cnt_d = '0;
      end
      rdy_d = cnt_d != (AW+1)'(D);
      vld_d = cnt_d != '0;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
         rdy_q <= 1'b1;
         vld_q <= 1'b0;
      end else begin
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
         rdy_q <= rdy_d;
         vld_q <= vld_d;
      end
   end

   // Storage; written only on an accepted beat
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end

   assign in_ready  = rdy_q;
   assign out_valid = vld_q;
   assign out_data  = mem_q[rp_q];
endmodule

module tmts_master
   import tmts_pkg::*;
#(
   parameter int DIV   = `TMTS_TCK_DIV,
   parameter int DEPTH = `TMTS_FIFO_DEPTH,
   parameter int LEN_W = `TMTS_LEN_W
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             cmd_wr,
   input  wire logic [7:0]       cmd_data,
   input  wire logic [LEN_W-1:0] scan_len,
   input  wire logic             discrete_mode,
   input  wire logic             disc_tms,
   input  wire logic             disc_tdo,
   input  wire logic             loopback,
   input  wire logic             wr_valid,
   input  wire logic [7:0]       wr_data,
   output logic                  wr_ready,
   output logic [7:0]            status_q,
   output logic                  loop_valid_q,
   output logic                  loop_bit_q,
   tmts_link_if.master           link
);
   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] HALF = CW'(DIV / 2);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   initial begin
      if (DIV < 4 || (DIV & (DIV - 1)) != 0) $error("tmts_master DIV must be a power of two >= 4");
      if (LEN_W < 1) $error("tmts_master LEN_W must be positive");
   end

   tmts_state_type    st_q, st_d, tgt;
   tmts_op_type       op_q, op_d;
   tmts_state_type    goal_q, goal_d;
   tmts_phase_type    ph_q, ph_d;
   logic [LEN_W-1:0]  left_q, left_d;
   logic [7:0]        sh_q, sh_d, fifo_data, status_d;
   logic [2:0]        nbit_q, nbit_d;
   logic [CW-1:0]     cnt_q, cnt_d;
   logic              tck_q, tck_d, tmsi_q, tmsi_d, tms_q, tms_d, tdo_q, tdo_d;
   logic              tdi_q, tdi_d, lv_d, lb_d, bit_o;
   logic              clr, rise, fall, in_shift, buffered, stall, pop, flush, fifo_valid;

   // shortest TMS walk toward a stable goal
   function automatic logic route(input tmts_state_type c, input tmts_state_type g);
      if (g == ts_tlr) return 1'b1;
      if (c == g) return 1'b0;
      case (c)
         ts_tlr:             return 1'b0;
         ts_seldr:           return !(g == ts_shdr || g == ts_pdr);
         ts_selir:           return !(g == ts_shir || g == ts_pir);
         ts_capdr, ts_ex2dr: return g != ts_shdr;
         ts_capir, ts_ex2ir: return g != ts_shir;
         ts_ex1dr:           return g != ts_pdr;
         ts_ex1ir:           return g != ts_pir;
         ts_updr, ts_upir:   return g != ts_rti;
         default:            return 1'b1;
      endcase
   endfunction

   tmts_fifo #(.W(8), .D(DEPTH)) u_fifo (
      .clk_sys   (clk_sys),
      .rst       (clr),
      .flush     (flush),
      .in_valid  (wr_valid),
      .in_data   (wr_data),
      .in_ready  (wr_ready),
      .out_valid (fifo_valid),
      .out_data  (fifo_data),
      .out_ready (pop)
   );

   // Sequencer: TCK divider, state tracking, TMS/TDO generation
   always_comb begin
      // software bit resets like the pin
      clr      = rst | (cmd_wr & cmd_data[`TMTS_CMD_SOFTWARE_RESET_BIT]);
      rise     = cnt_q == HALF - CW'(1);
      fall     = cnt_q == LAST;
      tgt      = (op_q == op_scan_ir) ? ts_shir : ts_shdr;
      if (ph_q == ph_go_end || ph_q == ph_idle) tgt = goal_q;
      in_shift = (ph_q == ph_go_shift || ph_q == ph_shift) && st_q == tgt;
      buffered = op_q == op_scan_dr || op_q == op_scan_ir;
      // Stall holds TCK high rather than shift a bit that is not there yet
      stall    = fall && in_shift && buffered && nbit_q == 3'h0 && !fifo_valid;
      st_d = st_q;  op_d = op_q;  goal_d = goal_q;  ph_d = ph_q;
      left_d = left_q;  sh_d = sh_q;  nbit_d = nbit_q;
      tmsi_d = tmsi_q;  tdo_d = tdo_q;  tdi_d = tdi_q;
      lv_d = 1'b0;  lb_d = loop_bit_q;  pop = 1'b0;  flush = 1'b0;  bit_o = 1'b1;
      cnt_d = stall ? cnt_q : cnt_q + CW'(1);
      tck_d = cnt_d >= HALF;
      // advance one state per rising TCK
      if (rise) begin
         st_d  = tmts_next(st_q, tmsi_q);
         tdi_d = link.t2m_data;
      end
      // outputs change only at falling TCK, except in discrete mode or when loopback forces them high
      if (fall && !stall) begin
         if (in_shift) begin
            tmsi_d = left_q == LEN_W'(1);
            left_d = left_q - LEN_W'(1);
            ph_d   = (left_q == LEN_W'(1)) ? ph_go_end : ph_shift;
            case (op_q)
               op_in_dr:  bit_o = 1'b1;
               op_recirc: bit_o = tdi_q;
               default: begin
                  if (nbit_q == 3'h0) begin
                     bit_o  = fifo_data[0];
                     sh_d   = {1'b0, fifo_data[7:1]};
                     nbit_d = 3'h7;
                     pop    = 1'b1;
                  end else begin
                     bit_o  = sh_q[0];
                     sh_d   = {1'b0, sh_q[7:1]};
                     nbit_d = nbit_q - 3'h1;
                  end
               end
            endcase
            // serialized bits also go to the loopback path
            lv_d = loopback;
            lb_d = bit_o;
         end else begin
            // select states always left by routing
            tmsi_d = route(st_q, tgt);
            if (ph_q == ph_go_end && st_q == goal_q) ph_d = ph_idle;
         end
         tdo_d = bit_o;
      end
      // discrete mode passes host levels straight out
      if (discrete_mode) begin
         tmsi_d = disc_tms;
         tdo_d  = disc_tdo;
      end else if (cmd_wr && ph_q == ph_idle) begin
         op_d   = tmts_op_type'(cmd_data[`TMTS_CMD_OP_HI:`TMTS_CMD_OP_LO]);
         case (cmd_data[`TMTS_CMD_END_HI:`TMTS_CMD_END_LO])
            2'h0:    goal_d = ts_tlr;
            2'h1:    goal_d = ts_rti;
            2'h2:    goal_d = ts_pdr;
            default: goal_d = ts_pir;
         endcase
         left_d = scan_len;
         nbit_d = 3'h0;
         flush  = 1'b1;
         ph_d   = (op_d == op_move || scan_len == '0) ? ph_go_end : ph_go_shift;
      end
      // target TMS and data held high in loopback; TCK keeps toggling
      tms_d = loopback | tmsi_d;
      if (loopback) tdo_d = 1'b1;
      status_d = `TMTS_STAT_RST;
      status_d[`TMTS_STAT_FULL] = !wr_ready;
      status_d[`TMTS_STAT_BUSY] = ph_d != ph_idle;
   end

   // reset drives TMS, TDO and test reset high
   always_ff @(posedge clk_sys) begin
      if (clr) begin
         st_q <= ts_tlr;  op_q <= op_move;  goal_q <= ts_tlr;  ph_q <= ph_idle;
         left_q <= '0;  sh_q <= 8'h00;  nbit_q <= 3'h0;  cnt_q <= '0;
         tck_q <= 1'b0;  tmsi_q <= 1'b1;  tms_q <= 1'b1;  tdo_q <= 1'b1;
         tdi_q <= 1'b1;  loop_valid_q <= 1'b0;  loop_bit_q <= 1'b0;
         status_q <= `TMTS_STAT_RST;
      end else begin
         st_q <= st_d;  op_q <= op_d;  goal_q <= goal_d;  ph_q <= ph_d;
         left_q <= left_d;  sh_q <= sh_d;  nbit_q <= nbit_d;  cnt_q <= cnt_d;
         tck_q <= tck_d;  tmsi_q <= tmsi_d;  tms_q <= tms_d;  tdo_q <= tdo_d;
         tdi_q <= tdi_d;  loop_valid_q <= lv_d;  loop_bit_q <= lb_d;
         status_q <= status_d;
      end
   end

   assign link.tck      = tck_q;
   assign link.tms      = tms_q;
   assign link.m2t_data = tdo_q;
   assign link.trst_n   = 1'b1;   // Test reset never pulsed; stays high
endmodule
`default_nettype wire

// [hw/tmts_target.sv]
// Scan target: a standard TAP controller with one data register and bypass.
// Assumes TCK and TMS arrive synchronous to clk_sys at well below its rate.
`timescale 1ns/1ps
`default_nettype none
`include "tmts_cfg.svh"

module tmts_target
   import tmts_pkg::*;
#(
   parameter int IR_W = `TMTS_IR_W,
   parameter int DR_W = `TMTS_DR_W
) (
   input  wire logic            clk_sys,
   input  wire logic            rst,
   input  wire logic [DR_W-1:0] cap_data,
   output logic [DR_W-1:0]      upd_data_q,
   output logic                 upd_pulse_q,
   output logic [IR_W-1:0]      instr_q,
   output logic [3:0]           state_q,
   tmts_link_if.target          link
);
   initial begin
      if (IR_W < 2 || DR_W < 1) $error("tmts_target register widths too small");
   end

   tmts_state_type  st_q, st_d;
   logic [IR_W-1:0] ir_sh_q, ir_sh_d, ir_d;
   logic [DR_W-1:0] dr_sh_q, dr_sh_d, upd_d;
   logic            byp_q, byp_d, tck_q, rise, fall, bypass;
   logic            out_q, out_d, oe_q, oe_d, upp_d;

   // TAP activity decoded from TCK edges seen on clk_sys
   always_comb begin
      rise   = link.tck & ~tck_q;
      fall   = ~link.tck & tck_q;
      bypass = &instr_q;
      st_d = st_q;  ir_sh_d = ir_sh_q;  dr_sh_d = dr_sh_q;  byp_d = byp_q;
      ir_d = instr_q;  upd_d = upd_data_q;  out_d = out_q;  oe_d = oe_q;  upp_d = 1'b0;
      if (rise) begin
         // state from TMS at rising edge
         st_d = tmts_next(st_q, link.tms);
         case (st_q)
            ts_capdr: begin
               dr_sh_d = cap_data;
               byp_d   = 1'b0;
            end
            ts_shdr: begin
               dr_sh_d = (DR_W > 1) ? {link.m2t_data, dr_sh_q[DR_W-1:1]} : link.m2t_data;
               byp_d   = link.m2t_data;
            end
            ts_capir: ir_sh_d = IR_W'(`TMTS_IR_CAP);
            ts_shir:  ir_sh_d = {link.m2t_data, ir_sh_q[IR_W-1:1]};
            // pause and exit states keep shift contents
            default:  ;
         endcase
      end
      if (fall) begin
         // drive LSB in shift, release elsewhere
         oe_d  = st_q == ts_shdr || st_q == ts_shir;
         out_d = (st_q == ts_shir) ? ir_sh_q[0] : (bypass ? byp_q : dr_sh_q[0]);
         if (st_q == ts_updr && !bypass) begin
            upd_d = dr_sh_q;
            upp_d = 1'b1;
         end
         // instruction takes effect on falling edge
         if (st_q == ts_upir) ir_d = ir_sh_q;
         if (st_q == ts_tlr) ir_d = '1;
      end
      // Test reset line forces the reset state at once
      if (!link.trst_n) begin
         st_d = ts_tlr;
         ir_d = '1;
         oe_d = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q <= ts_tlr;  ir_sh_q <= '0;  dr_sh_q <= '0;  byp_q <= 1'b0;
         instr_q <= '1;  upd_data_q <= '0;  upd_pulse_q <= 1'b0;
         out_q <= 1'b1;  oe_q <= 1'b0;  tck_q <= 1'b0;  state_q <= 4'hf;
      end else begin
         st_q <= st_d;  ir_sh_q <= ir_sh_d;  dr_sh_q <= dr_sh_d;  byp_q <= byp_d;
         instr_q <= ir_d;  upd_data_q <= upd_d;  upd_pulse_q <= upp_d;
         out_q <= out_d;  oe_q <= oe_d;  tck_q <= link.tck;  state_q <= st_d;
      end
   end

   // released at the TCK fall in Exit1, rescan needs no capture
   assign link.t2m_out = out_q;
   assign link.t2m_oe  = oe_q;
endmodule
`default_nettype wire

// [dv/tmts_link_chk.sv]
// Checker for the scan link: reset levels, edge timing of TMS and data, target drive.
// Assumes it sits beside the link interface, sampled on clk_sys with sync reset rst.
`timescale 1ns/1ps
`default_nettype none
module tmts_link_chk #(
   parameter int DIV = 16
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic discrete_mode,
   input wire logic tck,
   input wire logic tms,
   input wire logic m2t_data,
   input wire logic trst_n,
   input wire logic t2m_oe
);
   localparam int HALF = DIV / 2;
   localparam int FULL = DIV;
   logic tck_q, tck_d, tms_rise_q, tms_rise_d;

   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // TMS as the targets saw it at the latest TCK rise
   always_comb begin
      tck_d = tck;
      tms_rise_d = (tck && !tck_q) ? tms : tms_rise_q;
   end
   always_ff @(posedge clk_sys) begin
      tck_q <= rst ? 1'b0 : tck_d;
      tms_rise_q <= rst ? 1'b1 : tms_rise_d;
   end

   trst_high_a: assert property (trst_n)
      else $error("Test reset line went low");
   reset_tck_a: assert property ($fell(rst) |-> !tck)
      else $error("TCK not low on leaving reset");
   reset_idle_a: assert property ($fell(rst) |-> (tms && m2t_data) [*8])
      else $error("TMS or data low soon after reset");
   // Discrete mode drives the pins every clock, so edge timing is waived there
   tms_edge_a: assert property (disable iff (rst || discrete_mode)
      $changed(tms) |-> $fell(tck)) else $error("TMS moved away from a TCK fall");
   data_edge_a: assert property (disable iff (rst || discrete_mode)
      $changed(m2t_data) |-> $fell(tck)) else $error("Data moved away from a TCK fall");
   tck_low_a: assert property ($fell(tck) |-> ##[HALF:FULL] $rose(tck))
      else $error("TCK low phase has the wrong length");
   oe_fall_edge_a: assert property ($changed(t2m_oe) |->
      !$past(tck) && ($past(tck, 2) || $past(tck, 3))) else $error("Target drive moved late");
   oe_enter_a: assert property ($rose(t2m_oe) |-> !tms_rise_q)
      else $error("Target drove without a shift entry");
   oe_leave_a: assert property ($fell(t2m_oe) |-> tms_rise_q)
      else $error("Target released without an exit");

   cover property ($rose(t2m_oe));
   cover property ($fell(tck) && !tms);
   cover property (discrete_mode && !tms);
endmodule
`default_nettype wire

// [dv/tb.sv]
// Testbench joining scan master and target over the link, driving the host side.
// Assumes the design package, header and modules are compiled ahead of this file.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import tmts_pkg::*;
   localparam int DIV = 4;             // Short TCK keeps the run brief
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        cmd_wr = 1'b0;
   logic [7:0]  cmd_data = 8'h00;
   logic [15:0] scan_len = 16'h0000;
   logic        discrete_mode = 1'b0;
   logic        disc_tms = 1'b1;
   logic        disc_tdo = 1'b1;
   logic        loopback = 1'b0;
   logic        wr_valid = 1'b0;
   logic [7:0]  wr_data = 8'h00;
   logic [7:0]  cap_data = 8'h3c;
   logic        pin_bad = 1'b0;
   logic        wr_ready, loop_valid_q, loop_bit_q, upd_pulse_q, tck_p;
   logic [7:0]  status_q, upd_data_q, loop_bits;
   logic [3:0]  instr_q, state_q;
   logic [15:0] cap_bits;
   int          errors = 0;
   int          upd_count = 0;
   int          num_checks = 0;

   tmts_link_if link ();
   tmts_master #(.DIV(DIV)) tmts_master_i (.clk_sys(clk_sys), .rst(rst), .cmd_wr(cmd_wr),
      .cmd_data(cmd_data), .scan_len(scan_len), .discrete_mode(discrete_mode),
      .disc_tms(disc_tms), .disc_tdo(disc_tdo), .loopback(loopback), .wr_valid(wr_valid),
      .wr_data(wr_data), .wr_ready(wr_ready), .status_q(status_q),
      .loop_valid_q(loop_valid_q), .loop_bit_q(loop_bit_q), .link(link));
   tmts_target tmts_target_i (.clk_sys(clk_sys), .rst(rst), .cap_data(cap_data),
      .upd_data_q(upd_data_q), .upd_pulse_q(upd_pulse_q), .instr_q(instr_q),
      .state_q(state_q), .link(link));
   tmts_link_chk #(.DIV(DIV)) tmts_link_chk_i (.clk_sys(clk_sys), .rst(rst),
      .discrete_mode(discrete_mode), .tck(link.tck), .tms(link.tms),
      .m2t_data(link.m2t_data), .trst_n(link.trst_n), .t2m_oe(link.t2m_oe));

   always #20 clk_sys = ~clk_sys;

   // Target bits seen at TCK rises in Shift-DR, loopback bits, pins held, DR updates
   always @(posedge clk_sys) begin
      tck_p <= link.tck;
      if (link.tck && !tck_p && state_q == ts_shdr) begin
         cap_bits <= {link.t2m_data, cap_bits[15:1]};
      end
      if (loop_valid_q) begin
         loop_bits <= {loop_bit_q, loop_bits[7:1]};
      end
      if (upd_pulse_q) begin
         upd_count <= upd_count + 1;
      end
      if (loopback && !(link.tms && link.m2t_data)) begin
         pin_bad <= 1'b1;
      end
   end

   task automatic tick(input int n = 1);
      repeat (n) begin
         @(posedge clk_sys);
         #1;
      end
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("Checks made %0d, mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Byte write held until ready is seen at an edge; a gap cycle follows
   task automatic put(input logic [7:0] b);
      logic ok;
      ok = 1'b0;
      wr_valid = 1'b1;
      wr_data = b;
      for (int i = 0; i < 800 && ok !== 1'b1; i++) begin
         ok = wr_ready;
         tick();
      end
      if (ok !== 1'b1) begin
         errors++;
         conclude();
      end
      wr_valid = 1'b0;
      tick();
   endtask

   // Command strobe, busy shows at that edge; two more edges follow
   task automatic cmd(input logic [7:0] c, input logic [15:0] len);
      cmd_data = c;
      scan_len = len;
      cmd_wr = 1'b1;
      tick();
      cmd_wr = 1'b0;
      tick(2);
   endtask

   task automatic run(input tmts_op_type op, input logic [1:0] e, input logic [15:0] len,
                      input int n, input logic [15:0] d);
      cmd({1'b0, op, 2'b00, e}, len);
      for (int i = 0; i < n; i++) begin
         put(d[8*i +: 8]);
      end
      for (int i = 0; i < 800 && status_q[0] !== 1'b0; i++) begin
         tick();
      end
      if (status_q[0] !== 1'b0) begin
         errors++;
         conclude();
      end
      // Target acts on the last TCK fall a clock after the master drops busy
      tick(2);
   endtask

   initial begin
      tick(10);
      rst = 1'b0;
      tick(20);
      check("reset status", 16'(status_q), 16'h0000);
      check("reset ready", 16'(wr_ready), 16'h0001);
      check("reset state", 16'(state_q), 16'(ts_tlr));
      for (int i = 0; i < 4; i++) begin
         put(8'(i));
      end
      check("ready when full", 16'(wr_ready), 16'h0000);
      check("full flag", 16'(status_q[6]), 16'h0001);
      wr_valid = 1'b1;
      wr_data = 8'hee;
      tick(5);
      check("write held off", 16'(wr_ready), 16'h0000);
      wr_valid = 1'b0;
      cmd(8'h80, 16'h0000);
      check("soft reset status", 16'(status_q), 16'h0000);
      check("soft reset ready", 16'(wr_ready), 16'h0001);
      run(op_scan_ir, 2'h0, 16'h0004, 1, 16'h000a);
      check("ir to reset", 16'(state_q), 16'(ts_tlr));
      check("instr in reset", 16'(instr_q), 16'h000f);
      run(op_scan_ir, 2'h3, 16'h0004, 1, 16'h0009);
      check("ir to pause", 16'(state_q), 16'(ts_pir));
      check("instr before update", 16'(instr_q), 16'h000f);
      put(8'h0c);
      run(op_scan_ir, 2'h1, 16'h0004, 1, 16'h0005);
      check("ir to idle", 16'(state_q), 16'(ts_rti));
      check("instr after flush", 16'(instr_q), 16'h0005);
      run(op_scan_dr, 2'h2, 16'h000c, 2, 16'h0b34);
      check("dr to pause", 16'(state_q), 16'(ts_pdr));
      check("dr shifted out", 16'(cap_bits[15:4]), 16'h043c);
      run(op_move, 2'h1, 16'h0000, 0, 16'h0000);
      check("dr kept over pause", 16'(upd_data_q), 16'h00b3);
      run(op_in_dr, 2'h1, 16'h0008, 0, 16'h0000);
      check("input only", 16'(upd_data_q), 16'h00ff);
      run(op_recirc, 2'h1, 16'h0008, 0, 16'h0000);
      check("recirculate", 16'(upd_data_q), 16'h0079);
      check("update pulses", 16'(upd_count), 16'h0003);
      // Park in Test-Logic-Reset so TMS and data are already high when loopback pins them
      run(op_move, 2'h0, 16'h0000, 0, 16'h0000);
      check("parked in reset", 16'(state_q), 16'(ts_tlr));
      loopback = 1'b1;
      run(op_scan_dr, 2'h0, 16'h0008, 1, 16'h0096);
      check("loopback bits", 16'(loop_bits), 16'h0096);
      check("loopback pins", 16'(pin_bad), 16'h0000);
      loopback = 1'b0;
      discrete_mode = 1'b1;
      disc_tms = 1'b0;
      disc_tdo = 1'b0;
      tick(3);
      check("discrete tms", 16'(link.tms), 16'h0000);
      check("discrete data", 16'(link.m2t_data), 16'h0000);
      cmd({1'b0, op_scan_dr, 4'h1}, 16'h0008);
      check("command refused", 16'(status_q[0]), 16'h0000);
      disc_tms = 1'b1;
      disc_tdo = 1'b1;
      tick(3);
      discrete_mode = 1'b0;
      tick(4);
      conclude();
   end
endmodule
`default_nettype wire
